// ===== include/dlog_pkg.sv
package dlog_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 100; // one sample-period unit, 0.1 ms
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int SEC_S = 1; // one duration unit
  localparam int SEC_CYCLES = CLK_HZ * SEC_S;
  localparam logic [19:0] PERIOD_MIN = 20'd1; // 0.0001 s
  localparam logic [19:0] PERIOD_MAX = 20'd1000000; // 100 s
  localparam logic [25:0] DURATION_MAX = 26'd50000000; // seconds

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ARM = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_DURATION = 8'h0c;
  localparam logic [7:0] OFS_VLEVEL = 8'h10;
  localparam logic [7:0] OFS_VUP = 8'h14;
  localparam logic [7:0] OFS_VLOW = 8'h18;
  localparam logic [7:0] OFS_ILEVEL = 8'h1c;
  localparam logic [7:0] OFS_IUP = 8'h20;
  localparam logic [7:0] OFS_ILOW = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_BUS_TRG = 8'h2c;
  localparam logic [7:0] OFS_RECORDS = 8'h30;

  // control word fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EXT_BIT = 2;
  localparam int CTRL_LTRIG_LSB = 3;
  localparam int CTRL_LIST_LSB = 6;
  localparam int CTRL_PINCFG_BIT = 9;
  localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_004a;
  localparam logic [19:0] PERIOD_RESET = 20'h0000a;
  localparam logic [25:0] DURATION_RESET = 26'h000000a;

  typedef enum logic [1:0] {
    SRC_V = 2'h0,
    SRC_I = 2'h1,
    SRC_VI = 2'h2
  } source_t;

  typedef enum logic [2:0] {
    TRG_IMM = 3'h0,
    TRG_MANUAL = 3'h1,
    TRG_BUS = 3'h2,
    TRG_VOLT = 3'h3,
    TRG_CURR = 3'h4,
    TRG_EXT = 3'h5
  } trig_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b11
  } state_t;

endpackage : dlog_pkg

// ===== core/dlog_stats.sv
`timescale 1ns/1ps
`default_nettype none

module dlog_stats #(
  parameter int MW = 16,
  parameter int CW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic sample,
  input wire logic close,
  input wire logic ext,
  input wire logic [MW-1:0] value,
  output var logic valid,
  output var logic [MW-1:0] avg,
  output var logic [MW-1:0] max,
  output var logic [MW-1:0] min
);
  import dlog_pkg::*;

  typedef struct packed {
    logic [MW+CW-1:0] sum;
    logic [CW-1:0] cnt;
    logic [MW-1:0] mx;
    logic [MW-1:0] mn;
    logic valid;
    logic [MW-1:0] avg;
    logic [MW-1:0] omax;
    logic [MW-1:0] omin;
  } stats_t;

  stats_t st_q, st_d;

  // ----------------------------------------------------------------
  // accumulate and close one recording interval
  // ----------------------------------------------------------------
  // a sample landing on the close edge opens the next interval
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    if (clear) begin
      st_d.sum = '0;
      st_d.cnt = '0;
      st_d.mx = '0;
      st_d.mn = '0;
    end else if (close) begin
      st_d.valid = 1'b1;
      if (st_q.cnt != '0) begin
        st_d.avg = MW'(st_q.sum / st_q.cnt);
      end else begin
        st_d.avg = '0;
      end
      st_d.omax = ext ? st_q.mx : '0;
      st_d.omin = ext ? st_q.mn : '0;
      st_d.sum = sample ? (MW+CW)'(value) : '0;
      st_d.cnt = sample ? CW'(1) : '0;
      st_d.mx = sample ? value : '0;
      st_d.mn = sample ? value : '0;
    end else if (sample && st_q.cnt != '1) begin
      // saturating count: a very long interval stops widening
      st_d.sum = st_q.sum + (MW+CW)'(value);
      st_d.cnt = st_q.cnt + CW'(1);
      st_d.mx = (st_q.cnt == '0 || value > st_q.mx) ? value : st_q.mx;
      st_d.mn = (st_q.cnt == '0 || value < st_q.mn) ? value : st_q.mn;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign valid = st_q.valid;
  assign avg = st_q.avg;
  assign max = st_q.omax;
  assign min = st_q.omin;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_AVG_IN_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (close && !clear && ext && st_q.cnt != '0) |=>
      (valid && avg <= max && avg >= min))
    else $error("average outside max/min");

  AST_EXT_GATED: assert property (
    @(posedge pclk) disable iff (!presetn)
    (close && !clear && !ext) |=> (max == '0 && min == '0))
    else $error("max/min reported without extended type");

endmodule : dlog_stats

`default_nettype wire

// ===== core/dlog_core.sv
`timescale 1ns/1ps
`default_nettype none

module dlog_core #(
  parameter int TICK_CYC = dlog_pkg::TICK_CYCLES,
  parameter int SEC_CYC = dlog_pkg::SEC_CYCLES,
  parameter int MW = 16,
  parameter int CW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dlog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic meas_valid,
  input wire logic [MW-1:0] volt_meas,
  input wire logic [MW-1:0] curr_meas,
  input wire logic key_trigger,
  input wire logic ext_trig_pin,
  input wire logic storage_present,
  input wire logic host_usb_connected,
  output var logic logging_active,
  output var logic v_rec_valid,
  output var logic [MW-1:0] v_avg,
  output var logic [MW-1:0] v_max,
  output var logic [MW-1:0] v_min,
  output var logic i_rec_valid,
  output var logic [MW-1:0] i_avg,
  output var logic [MW-1:0] i_max,
  output var logic [MW-1:0] i_min
);
  import dlog_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int SW = $clog2(SEC_CYC + 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYC < 1 || SEC_CYC < 1 || MW < 2 || MW > 32 || CW < 2) begin : g_chk
    $error("dlog_core: unsupported parameter values");
  end

  typedef struct packed {
    logic [1:0] key_s;
    logic [1:0] ext_s;
    logic [1:0] stor_s;
    logic [1:0] usb_s;
    logic key_p;
    logic ext_p;
    logic [31:0] ctrl;
    logic [19:0] period;
    logic [25:0] duration;
    logic [MW-1:0] vlev;
    logic [MW-1:0] vup;
    logic [MW-1:0] vlow;
    logic [MW-1:0] ilev;
    logic [MW-1:0] iup;
    logic [MW-1:0] ilow;
    state_t state;
    logic [TW-1:0] tick;
    logic [19:0] pcnt;
    logic [SW-1:0] scnt;
    logic [25:0] elapsed;
    logic [31:0] records;
    logic bus_trg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic active;
  } core_t;

  core_t st_q, st_d;
  logic ok_w, fire_w, arm_w, start_w, rec_w, v_on, i_on;
  trig_t sel_w;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFS_RECORDS);
  endfunction : is_mapped

  // reached the level and lies inside the window
  function automatic logic in_window(input logic [MW-1:0] m,
      input logic [MW-1:0] lev, input logic [MW-1:0] up,
      input logic [MW-1:0] low);
    in_window = (m >= lev) && (m <= up) && (m >= low);
  endfunction : in_window

  function automatic logic [MW-1:0] lo_word(input logic [31:0] w);
    lo_word = w[MW-1:0];
  endfunction : lo_word

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    arm_w = 1'b0;
    start_w = 1'b0;
    rec_w = 1'b0;
    fire_w = 1'b0;
    // pins pass two flops before anything looks at them
    st_d.key_s = {st_q.key_s[0], key_trigger};
    st_d.ext_s = {st_q.ext_s[0], ext_trig_pin};
    st_d.stor_s = {st_q.stor_s[0], storage_present};
    st_d.usb_s = {st_q.usb_s[0], host_usb_connected};
    st_d.key_p = st_q.key_s[1];
    st_d.ext_p = st_q.ext_s[1];
    st_d.bus_trg = 1'b0;

    // apb: answer prepared in setup, one-cycle access phase
    st_d.pready = psel & ~penable;
    st_d.pslverr = psel & ~penable & ~is_mapped(paddr);
    st_d.prdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: st_d.prdata = st_q.ctrl;
        OFS_PERIOD: st_d.prdata = {12'h000, st_q.period};
        OFS_DURATION: st_d.prdata = {6'h00, st_q.duration};
        OFS_VLEVEL: st_d.prdata = 32'(st_q.vlev);
        OFS_VUP: st_d.prdata = 32'(st_q.vup);
        OFS_VLOW: st_d.prdata = 32'(st_q.vlow);
        OFS_ILEVEL: st_d.prdata = 32'(st_q.ilev);
        OFS_IUP: st_d.prdata = 32'(st_q.iup);
        OFS_ILOW: st_d.prdata = 32'(st_q.ilow);
        OFS_STATUS: st_d.prdata = {26'h0000000, st_q.usb_s[1],
            st_q.stor_s[1], st_q.elapsed >= st_q.duration, st_q.active,
            st_q.state};
        OFS_RECORDS: st_d.prdata = st_q.records;
        default: st_d.prdata = '0;
      endcase
    end
    if (psel && penable && st_q.pready && pwrite) begin
      case (paddr)
        OFS_CTRL: st_d.ctrl = pwdata & CTRL_MASK;
        OFS_ARM: arm_w = pwdata[0];
        // out-of-range periods are clamped to the legal span
        OFS_PERIOD: begin
          if (pwdata < 32'(PERIOD_MIN)) begin
            st_d.period = PERIOD_MIN;
          end else if (pwdata > 32'(PERIOD_MAX)) begin
            st_d.period = PERIOD_MAX;
          end else begin
            st_d.period = pwdata[19:0];
          end
        end
        OFS_DURATION: begin
          if (pwdata > 32'(DURATION_MAX)) begin
            st_d.duration = DURATION_MAX;
          end else begin
            st_d.duration = pwdata[25:0];
          end
        end
        OFS_VLEVEL: st_d.vlev = lo_word(pwdata);
        OFS_VUP: st_d.vup = lo_word(pwdata);
        OFS_VLOW: st_d.vlow = lo_word(pwdata);
        OFS_ILEVEL: st_d.ilev = lo_word(pwdata);
        OFS_IUP: st_d.iup = lo_word(pwdata);
        OFS_ILOW: st_d.ilow = lo_word(pwdata);
        OFS_BUS_TRG: st_d.bus_trg = 1'b1;
        default: st_d.bus_trg = 1'b0;
      endcase
    end

    // trigger source decode, logging select only
    ok_w = st_q.stor_s[1] & ~st_q.usb_s[1];
    sel_w = trig_t'(st_q.ctrl[CTRL_LTRIG_LSB +: 3]);
    case (sel_w)
      TRG_IMM: fire_w = 1'b1;
      TRG_MANUAL: fire_w = st_q.key_s[1] & ~st_q.key_p;
      TRG_BUS: fire_w = st_q.bus_trg;
      TRG_VOLT: fire_w = meas_valid & in_window(volt_meas, st_q.vlev,
          st_q.vup, st_q.vlow);
      TRG_CURR: fire_w = meas_valid & in_window(curr_meas, st_q.ilev,
          st_q.iup, st_q.ilow);
      TRG_EXT: fire_w = st_q.ctrl[CTRL_PINCFG_BIT] & st_q.ext_s[1] &
          ~st_q.ext_p;
      default: fire_w = 1'b0;
    endcase

    // run control
    case (st_q.state)
      ST_IDLE: begin
        if (arm_w && ok_w) begin
          st_d.state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!ok_w) begin
          st_d.state = ST_IDLE;
        end else if (fire_w) begin
          st_d.state = ST_RUN;
          start_w = 1'b1;
          st_d.tick = '0;
          st_d.pcnt = '0;
          st_d.scnt = '0;
          st_d.elapsed = '0;
          st_d.records = '0;
        end
      end
      ST_RUN: begin
        // triggers are not looked at here, so a run cannot restart
        if (!ok_w) begin
          st_d.state = ST_IDLE;
        end else if (st_q.elapsed >= st_q.duration) begin
          st_d.state = ST_IDLE;
        end else begin
          if (st_q.tick == TW'(TICK_CYC - 1)) begin
            st_d.tick = '0;
            if (st_q.pcnt == st_q.period - 20'd1) begin
              st_d.pcnt = '0;
              rec_w = 1'b1;
              st_d.records = st_q.records + 32'd1;
            end else begin
              st_d.pcnt = st_q.pcnt + 20'd1;
            end
          end else begin
            st_d.tick = st_q.tick + TW'(1);
          end
          if (st_q.scnt == SW'(SEC_CYC - 1)) begin
            st_d.scnt = '0;
            st_d.elapsed = st_q.elapsed + 26'd1;
          end else begin
            st_d.scnt = st_q.scnt + SW'(1);
          end
        end
      end
      default: st_d.state = ST_IDLE;
    endcase
    st_d.active = (st_d.state == ST_RUN);

    // which quantities the run records
    v_on = (st_q.ctrl[CTRL_SRC_LSB +: 2] != SRC_I);
    i_on = (st_q.ctrl[CTRL_SRC_LSB +: 2] != SRC_V);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RESET;
      st_q.period <= PERIOD_RESET;
      st_q.duration <= DURATION_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign logging_active = st_q.active;

  // ----------------------------------------------------------------
  // per-quantity statistics
  // ----------------------------------------------------------------
  dlog_stats #(.MW(MW), .CW(CW)) u_vstat (
    .pclk(pclk),
    .presetn(presetn),
    .clear(start_w),
    .sample(meas_valid & st_q.active & v_on),
    .close(rec_w & v_on),
    .ext(st_q.ctrl[CTRL_EXT_BIT]),
    .value(volt_meas),
    .valid(v_rec_valid),
    .avg(v_avg),
    .max(v_max),
    .min(v_min)
  );

  dlog_stats #(.MW(MW), .CW(CW)) u_istat (
    .pclk(pclk),
    .presetn(presetn),
    .clear(start_w),
    .sample(meas_valid & st_q.active & i_on),
    .close(rec_w & i_on),
    .ext(st_q.ctrl[CTRL_EXT_BIT]),
    .value(curr_meas),
    .valid(i_rec_valid),
    .avg(i_avg),
    .max(i_max),
    .min(i_min)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_armed_ok;
    st_q.state == ST_ARMED && ok_w;
  endsequence

  sequence s_fresh_run;
    st_q.tick == '0 && st_q.elapsed == '0 && st_q.records == '0;
  endsequence

  AST_NO_STORAGE: assert property (
    (st_q.state != ST_RUN && !st_q.stor_s[1]) |=> !logging_active)
    else $error("run started without storage");

  AST_USB_STOPS: assert property (
    st_q.usb_s[1] |=> (st_q.state == ST_IDLE && !logging_active))
    else $error("logging continued with host usb attached");

  AST_IMM_START: assert property (
    (s_armed_ok and (sel_w == TRG_IMM)) |=> logging_active)
    else $error("immediate trigger did not start");

  AST_BUS_START: assert property (
    (s_armed_ok and (sel_w == TRG_BUS) and st_q.bus_trg) |=> logging_active)
    else $error("bus trigger did not start");

  AST_VOLT_START: assert property (
    (s_armed_ok and (sel_w == TRG_VOLT) and meas_valid and
     (volt_meas >= st_q.vlev) and (volt_meas <= st_q.vup) and
     (volt_meas >= st_q.vlow)) |=> logging_active)
    else $error("voltage trigger did not start");

  AST_EXT_CFG: assert property (
    (st_q.state == ST_ARMED && sel_w == TRG_EXT &&
     !st_q.ctrl[CTRL_PINCFG_BIT]) |=> !logging_active)
    else $error("unconfigured pin started a run");

  AST_FRESH_COUNTS: assert property (
    $rose(logging_active) |-> s_fresh_run)
    else $error("counters not cleared at run start");

  AST_NO_RETRIGGER: assert property (
    (st_q.state == ST_RUN) |=> (st_q.state != ST_ARMED && !start_w))
    else $error("trigger accepted during a run");

  AST_DURATION_END: assert property (
    (st_q.state == ST_RUN && st_q.elapsed >= st_q.duration) |=>
      (st_q.state == ST_IDLE) ##1 !logging_active)
    else $error("run outlived its duration");

  AST_SRC_V_ONLY: assert property (
    (st_q.ctrl[1:0] == SRC_V && st_q.state == ST_RUN) |=> !i_rec_valid)
    else $error("current recorded with voltage-only source");

endmodule : dlog_core

`default_nettype wire

// ===== test/dlog_front_model.sv
`timescale 1ns/1ps
`default_nettype none

module dlog_front_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [15:0] lo,
  input wire logic [15:0] hi,
  output var logic meas_valid,
  output var logic [15:0] volt_meas,
  output logic [15:0] curr_meas
);
  logic [1:0] cnt_q;
  logic ph_q;

  // sample each cycle, or one in three when slow; values alternate
  // lo/hi; off-strobe the bus inverts each cycle: the inverted sample, then the last sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      ph_q <= 1'b0;
      meas_valid <= 1'b0;
      volt_meas <= 16'h0000;
    end else begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      meas_valid <= !slow || cnt_q == 2'h0;
      if (!slow || cnt_q == 2'h0) begin
        ph_q <= !ph_q;
        volt_meas <= ph_q ? hi : lo;
      end else begin
        volt_meas <= ~volt_meas;
      end
    end
  end

  // both channels read the same stimulus
  assign curr_meas = volt_meas;
endmodule : dlog_front_model

`default_nettype wire

// ===== test/dlog_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module dlog_core_tb_top;
  import dlog_pkg::*;
  localparam int SC = 40;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, mv, er, act, v_vld, i_vld;
  logic key = 0, ext = 0, sto = 1, usb = 0, slow = 0;
  logic [15:0] lo = 16'h0, hi = 16'h0, vm, cm;
  logic [15:0] v_avg, v_max, v_min, i_avg, i_max, i_min;
  int err_total = 0, checked = 0, vcnt = 0, icnt = 0, n;

  always #5 pclk = ~pclk;

  // small tick and second counts keep runs short
  dlog_core #(.TICK_CYC(4), .SEC_CYC(SC)) dlog_core_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(mv), .volt_meas(vm), .curr_meas(cm),
    .key_trigger(key), .ext_trig_pin(ext), .storage_present(sto),
    .host_usb_connected(usb), .logging_active(act), .v_rec_valid(v_vld),
    .v_avg(v_avg), .v_max(v_max), .v_min(v_min), .i_rec_valid(i_vld),
    .i_avg(i_avg), .i_max(i_max), .i_min(i_min));
  dlog_front_model dlog_front_model_i (.pclk(pclk), .presetn(presetn),
    .slow(slow), .lo(lo), .hi(hi), .meas_valid(mv), .volt_meas(vm),
    .curr_meas(cm));

  // record pulses per channel
  always @(posedge pclk) begin
    if (v_vld === 1'b1) vcnt++;
    if (i_vld === 1'b1) icnt++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // apb: setup, access, wait for pready under a bound
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // bounded wait for the run flag; n == lim means it never came
  task automatic wact(input logic e, input int lim);
    n = 0;
    while (act !== e && n < lim) begin
      @(posedge pclk);
      n++;
    end
    // a run that never ends is a hang, not a result
    if (e == 1'b0 && act !== 1'b0) begin
      err_total++;
      complete_run();
    end
  endtask : wact

  function automatic logic [31:0] cw(input logic [1:0] s, input logic x,
      input logic [2:0] t, input logic p);
    return {22'h0, p, 3'h5, t, x, s};
  endfunction : cw

  task automatic run(input logic [31:0] c);
    xfer(1'b1, OFS_CTRL, c);
    xfer(1'b1, OFS_ARM, 32'h1);
  endtask : run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000004a);
    xfer(1'b0, OFS_PERIOD, 32'h0);
    chk(rd, 32'h0000000a);
    xfer(1'b0, OFS_DURATION, 32'h0);
    chk(rd, 32'h0000000a);
    xfer(1'b0, 8'h34, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    xfer(1'b1, OFS_CTRL, cw(SRC_V, 1'b0, TRG_BUS, 1'b0));
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, cw(SRC_V, 1'b0, TRG_BUS, 1'b0));
    $display("reset test done");
  endtask : t_reset

  task automatic t_imm();
    int first;
    lo <= 16'h1234;
    hi <= 16'h1234;
    xfer(1'b1, OFS_PERIOD, 32'h2);
    xfer(1'b1, OFS_DURATION, 32'h1);
    // second run must restart both counters
    for (int r = 0; r < 2; r++) begin
      vcnt = 0;
      icnt = 0;
      run(cw(SRC_V, 1'b0, TRG_IMM, 1'b0));
      wact(1'b1, 10);
      chk({31'h0, n < 10}, 32'h1);
      wact(1'b0, 300);
      chk({31'h0, n >= SC - 2 && n <= SC + 4}, 32'h1);
      chk({31'h0, vcnt inside {[4:5]}}, 32'h1);
      chk(32'(icnt), 32'h0);
      chk({16'h0, v_avg}, 32'h1234);
      chk({16'h0, v_max}, 32'h0);
      chk({16'h0, v_min}, 32'h0);
      xfer(1'b0, OFS_RECORDS, 32'h0);
      chk(rd, 32'(vcnt));
      if (r == 0) first = vcnt;
      else chk(32'(vcnt), 32'(first));
    end
    $display("immediate test done");
  endtask : t_imm

  task automatic t_ext();
    lo <= 16'h0100;
    hi <= 16'h0300;
    slow <= 1'b1;
    vcnt = 0;
    run(cw(SRC_I, 1'b1, TRG_BUS, 1'b0));
    wact(1'b1, 20);
    chk(32'(n), 32'd20);
    xfer(1'b1, OFS_BUS_TRG, 32'h1);
    wact(1'b1, 5);
    chk({31'h0, n < 5}, 32'h1);
    n = 0;
    while (i_vld !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 50}, 32'h1);
    chk({16'h0, i_max}, 32'h0300);
    chk({16'h0, i_min}, 32'h0100);
    chk({31'h0, i_avg >= lo && i_avg <= hi}, 32'h1);
    // a second command mid-run must not restart the counters
    xfer(1'b1, OFS_BUS_TRG, 32'h1);
    wact(1'b0, 300);
    xfer(1'b0, OFS_RECORDS, 32'h0);
    chk(rd, 32'(SC / 8));
    chk(32'(vcnt), 32'h0);
    xfer(1'b1, OFS_BUS_TRG, 32'h1);
    wact(1'b1, 20);
    chk(32'(n), 32'd20);
    slow <= 1'b0;
    $display("extended bus test done");
  endtask : t_ext

  task automatic t_window();
    logic [15:0] val [3] = '{16'h0060, 16'h0300, 16'h0100};
    logic [7:0] b;
    for (int k = 0; k < 2; k++) begin
      b = k ? OFS_ILEVEL : OFS_VLEVEL;
      // stale in-window stimulus would fire the trigger on arming
      lo <= val[0];
      hi <= val[0];
      xfer(1'b1, b, 32'h80);
      xfer(1'b1, b + 8'h04, 32'h200);
      xfer(1'b1, b + 8'h08, 32'h40);
      vcnt = 0;
      icnt = 0;
      run(cw(SRC_VI, 1'b0, k ? TRG_CURR : TRG_VOLT, 1'b0));
      // below level, above window, then inside
      for (int j = 0; j < 3; j++) begin
        lo <= val[j];
        hi <= val[j];
        wact(1'b1, 20);
        chk({31'h0, n < 20}, {31'h0, j == 2});
      end
      wact(1'b0, 300);
      chk({31'h0, vcnt > 0 && icnt > 0}, 32'h1);
    end
    $display("window test done");
  endtask : t_window

  task automatic pulse(input int k);
    @(posedge pclk);
    if (k == 0) ext <= 1'b1;
    else key <= 1'b1;
    repeat (4) @(posedge pclk);
    ext <= 1'b0;
    key <= 1'b0;
  endtask : pulse

  task automatic t_pins();
    run(cw(SRC_V, 1'b0, TRG_EXT, 1'b0));
    pulse(0);
    wact(1'b1, 20);
    chk(32'(n), 32'd20);
    run(cw(SRC_V, 1'b0, TRG_EXT, 1'b1));
    pulse(0);
    wact(1'b1, 10);
    chk({31'h0, n < 10}, 32'h1);
    wact(1'b0, 300);
    run(cw(SRC_V, 1'b0, TRG_MANUAL, 1'b0));
    pulse(1);
    wact(1'b1, 10);
    chk({31'h0, n < 10}, 32'h1);
    wact(1'b0, 300);
    $display("pin test done");
  endtask : t_pins

  task automatic t_guard();
    // absent storage, then host usb, each must block the start
    for (int k = 0; k < 2; k++) begin
      sto <= (k == 1);
      usb <= (k == 1);
      repeat (4) @(posedge pclk);
      run(cw(SRC_V, 1'b0, TRG_IMM, 1'b0));
      wact(1'b1, 20);
      chk(32'(n), 32'd20);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h0);
    end
    usb <= 1'b0;
    repeat (4) @(posedge pclk);
    run(cw(SRC_V, 1'b0, TRG_IMM, 1'b0));
    wact(1'b1, 10);
    usb <= 1'b1;
    wact(1'b0, 8);
    chk({31'h0, n < 8}, 32'h1);
    usb <= 1'b0;
    $display("guard test done");
  endtask : t_guard

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_imm();
    t_ext();
    t_window();
    t_pins();
    t_guard();
    complete_run();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    complete_run();
  end
endmodule : dlog_core_tb_top

`default_nettype wire
